// *** design/psb_map.svh ***
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH

// ==============================================================
// register offsets
`define PSB_OFS_CONFIG_STATUS     8'h00
`define PSB_OFS_OPERATING_STATUS  8'h01
`define PSB_OFS_CELL_BALANCE      8'h02

// ==============================================================
// configuration status field positions
`define PSB_CFG_UPPER_BIT         7
`define PSB_CFG_LOWER_BIT         6
`define PSB_CFG_VARIANT_BIT       5
`define PSB_CFG_WAKE_BIT          4

// ==============================================================
// cell balance field positions
`define PSB_BAL_WAKE_BIT          6
`define PSB_BAL_CELL7_BIT         7

// ==============================================================
// reset values and bus constants
`define PSB_BAL_RESET             8'h00
`define PSB_READ_ZERO             8'h00
`define PSB_BITS_PER_BYTE         4'h8
`define PSB_DEV_ADDR_DEFAULT      7'h28

`endif

// *** design/psb_pkg.sv ***
package psb_pkg;

    // ==============================================================
    // fault conditions from the protection detectors, same clock
    typedef struct packed {
        logic ext_overtemp;
        logic int_overtemp;
        logic load_heavy;
        logic discharge_short;
        logic discharge_overcurrent;
        logic charge_overcurrent;
    } psb_cond_t;

    // latched flags, operating status bits 5..0
    typedef struct packed {
        logic external_overtemp_flag;
        logic internal_overtemp_flag;
        logic load_fail_flag;
        logic discharge_short_flag;
        logic discharge_overcurrent_flag;
        logic charge_overcurrent_flag;
    } psb_flags_t;

    // ==============================================================
    // serial slave states
    typedef enum logic [2:0] {
        PSB_IDLE,
        PSB_ADDR,
        PSB_ADDR_ACK,
        PSB_WR_BYTE,
        PSB_WR_ACK,
        PSB_RD_BYTE,
        PSB_RD_ACK
    } psb_state_t;

    // ==============================================================
    // whole state of the register bank
    typedef struct packed {
        psb_state_t state;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic       rw;
        logic       ptr_phase;
        logic       scl_prev;
        logic       sda_prev;
        logic       sda_oe;
        psb_flags_t flags;
        logic [7:0] balance_reg;
        logic [7:1] balance_out;
        logic       wake_req;
    } psb_regs_t;

endpackage

// *** design/psb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; the first stage feeds only the second
module psb_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // ==============================================================
    // resync chain, idles high like the bus lines
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;

endmodule

`default_nettype wire

// *** design/psb_status_balance_regs.sv ***
// Overview of operation
// R1 - config status bit 7 reads one on the upper device, fixed, writes ignored
// R2 - config status bit 6 reads one on the lower device, fixed, writes ignored
// R3 - config status bit 5 is a variant bit with no function here
// R4 - config bit 4 shows wake pin above or below threshold per polarity
// R5 - status bit 5 latches external overtemp, clears on read once gone
// R6 - status bit 4 latches internal overtemp, clears on read once gone
// R7 - status bit 3 latches load fail when monitoring, clears on read once gone
// R8 - status bit 2 latches discharge short, clears on read once removed
// R9 - status bit 1 latches discharge overcurrent, clears on read once removed
// R10 - status bit 0 latches charge overcurrent, clears on read once ended
// R11 - balance bits 1..7 switch cells 1..7 on or off; bit 0 unused
// R12 - balance bit 6 also drives the wake request output
// R13 - balance bit 7 balances cell 7 only on the upper device
// R14 - wake request output exists only on the lower device
// R15 - latched fault flags clear on read; other status follows its condition
// R16 - host writes zero to reserved bits and ignores them on reads
// R17 - upper device reads lower-only status as zero; writable bits hold inertly
// R18 - read clear acts after data capture so a new set is never lost
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"

module psb_status_balance_regs
    import psb_pkg::*;
#(
    parameter bit       UPPER_DEVICE = 1'b0,
    parameter bit [6:0] DEV_ADDR     = `PSB_DEV_ADDR_DEFAULT
) (
    input  wire logic      i_sys_clk,
    input  wire logic      i_sys_rst,
    input  wire logic      i_scl,
    input  wire logic      i_sda,
    output logic           o_sda_o,
    output logic           o_sda_oe,
    input  wire logic      i_wake_pin_above,
    input  wire logic      i_wake_polarity,
    input  wire logic      i_load_monitor,
    input  wire psb_cond_t i_cond,
    output logic     [7:1] o_balance_on,
    output logic           o_wake_request_out
);

    psb_regs_t r_q;
    psb_regs_t r_d;
    logic      scl_s;
    logic      sda_s;
    logic      wake_above_s;

    // ==============================================================
    // pin resync
    psb_sync #(.W(3)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_d       ({i_scl, i_sda, i_wake_pin_above}),
        .o_q       ({scl_s, sda_s, wake_above_s})
    );

    // ==============================================================
    // register read decode, reserved and unmapped bits read zero
    function automatic logic [7:0] read_mux(input logic [7:0] ofs,
                                           input psb_flags_t fl,
                                           input logic [7:0] bal,
                                           input logic wake_state);
        logic [7:0] v;
        v = `PSB_READ_ZERO;
        case (ofs)
            `PSB_OFS_CONFIG_STATUS: begin
                v[`PSB_CFG_UPPER_BIT]   = UPPER_DEVICE;   // [R1]
                v[`PSB_CFG_LOWER_BIT]   = !UPPER_DEVICE;  // [R2]
                v[`PSB_CFG_VARIANT_BIT] = 1'b0;           // [R3]
                v[`PSB_CFG_WAKE_BIT]    = wake_state;     // [R4]
            end
            `PSB_OFS_OPERATING_STATUS: begin
                v[5:0] = fl;
            end
            `PSB_OFS_CELL_BALANCE: begin
                v[7:1] = bal[7:1];  // bit 0 unused, reads zero [R11]
            end
            default: begin
                v = `PSB_READ_ZERO;
            end
        endcase
        return v;
    endfunction

    // ==============================================================
    // next-state logic
    always_comb begin
        logic       rise;
        logic       fall;
        logic       start;
        logic       stop;
        logic       load_rd;
        logic       do_clr;
        logic       wake_state;
        logic [7:0] rd_byte;
        psb_flags_t cond;
        psb_flags_t clr_mask;

        r_d        = r_q;
        rise       = scl_s && !r_q.scl_prev;
        fall       = !scl_s && r_q.scl_prev;
        start      = scl_s && r_q.scl_prev && r_q.sda_prev && !sda_s;
        stop       = scl_s && r_q.scl_prev && !r_q.sda_prev && sda_s;
        load_rd    = 1'b0;
        do_clr     = 1'b0;
        rd_byte    = `PSB_READ_ZERO;
        clr_mask   = '0;
        cond       = '0;
        // polarity selects which side of threshold counts as awake [R4]
        wake_state = i_wake_polarity ? wake_above_s : !wake_above_s;

        r_d.scl_prev = scl_s;
        r_d.sda_prev = sda_s;

        if (start) begin
            r_d.state   = PSB_ADDR;
            r_d.bit_cnt = '0;
            r_d.sda_oe  = 1'b0;
        end else if (stop) begin
            r_d.state  = PSB_IDLE;
            r_d.sda_oe = 1'b0;
        end else begin
            case (r_q.state)
                PSB_IDLE: begin
                    r_d.sda_oe = 1'b0;
                end
                PSB_ADDR: begin
                    if (rise) begin
                        r_d.shreg   = {r_q.shreg[6:0], sda_s};
                        r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                    end else if (fall && r_q.bit_cnt == `PSB_BITS_PER_BYTE) begin
                        // only our own address is acknowledged
                        if (r_q.shreg[7:1] == DEV_ADDR) begin
                            r_d.rw     = r_q.shreg[0];
                            r_d.sda_oe = 1'b1;
                            r_d.state  = PSB_ADDR_ACK;
                        end else begin
                            r_d.state = PSB_IDLE;
                        end
                        r_d.bit_cnt = '0;
                    end
                end
                PSB_ADDR_ACK: begin
                    if (fall) begin
                        if (r_q.rw) begin
                            load_rd = 1'b1;
                        end else begin
                            r_d.sda_oe    = 1'b0;
                            r_d.ptr_phase = 1'b1;
                            r_d.state     = PSB_WR_BYTE;
                        end
                    end
                end
                PSB_WR_BYTE: begin
                    if (rise) begin
                        r_d.shreg   = {r_q.shreg[6:0], sda_s};
                        r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                    end else if (fall && r_q.bit_cnt == `PSB_BITS_PER_BYTE) begin
                        if (r_q.ptr_phase) begin
                            r_d.ptr       = r_q.shreg;
                            r_d.ptr_phase = 1'b0;
                        end else begin
                            // only balance is writable; status writes are ignored [R1] [R2]
                            if (r_q.ptr == `PSB_OFS_CELL_BALANCE) begin
                                r_d.balance_reg = {r_q.shreg[7:1], 1'b0};  // [R11]
                            end
                            r_d.ptr = r_q.ptr + 8'h01;
                        end
                        r_d.sda_oe  = 1'b1;
                        r_d.bit_cnt = '0;
                        r_d.state   = PSB_WR_ACK;
                    end
                end
                PSB_WR_ACK: begin
                    if (fall) begin
                        r_d.sda_oe = 1'b0;
                        r_d.state  = PSB_WR_BYTE;
                    end
                end
                PSB_RD_BYTE: begin
                    if (rise) begin
                        r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                    end else if (fall) begin
                        if (r_q.bit_cnt == `PSB_BITS_PER_BYTE) begin
                            r_d.sda_oe = 1'b0;  // let the host acknowledge
                            r_d.state  = PSB_RD_ACK;
                        end else begin
                            r_d.shreg  = {r_q.shreg[6:0], 1'b0};
                            r_d.sda_oe = !r_q.shreg[6];
                        end
                    end
                end
                PSB_RD_ACK: begin
                    if (rise && sda_s) begin
                        r_d.state = PSB_IDLE;  // host nack ends the read
                    end else if (fall) begin
                        load_rd = 1'b1;
                    end
                end
                default: begin
                    r_d.state = PSB_IDLE;
                end
            endcase
        end

        // read byte is captured here; the clear uses that same snapshot
        if (load_rd) begin
            rd_byte     = read_mux(r_q.ptr, r_q.flags, r_q.balance_reg, wake_state);
            r_d.shreg   = rd_byte;
            r_d.sda_oe  = !rd_byte[7];
            r_d.ptr     = r_q.ptr + 8'h01;
            r_d.bit_cnt = '0;
            r_d.state   = PSB_RD_BYTE;
            do_clr      = (r_q.ptr == `PSB_OFS_OPERATING_STATUS);  // [R15]
        end

        // ==========================================================
        // fault flag latching
        cond.external_overtemp_flag     = i_cond.ext_overtemp;          // [R5]
        cond.internal_overtemp_flag     = i_cond.int_overtemp;          // [R6]
        cond.load_fail_flag             = i_load_monitor && i_cond.load_heavy &&
                                          (i_cond.discharge_short ||
                                           i_cond.discharge_overcurrent);  // [R7]
        cond.discharge_short_flag       = i_cond.discharge_short;       // [R8]
        cond.discharge_overcurrent_flag = i_cond.discharge_overcurrent; // [R9]
        cond.charge_overcurrent_flag    = i_cond.charge_overcurrent;    // [R10]
        if (UPPER_DEVICE) begin
            // lower-only flags stay zero on the upper device [R17]
            cond = cond & 6'h10;
        end
        if (do_clr) begin
            clr_mask = r_q.flags;
        end
        // a live condition re-sets the bit, so set wins over clear [R18] [R5] [R10]
        r_d.flags = cond | (r_q.flags & ~clr_mask);

        // ==========================================================
        // balance switch and wake request drive
        r_d.balance_out = r_q.balance_reg[7:1];  // [R11]
        if (!UPPER_DEVICE) begin
            r_d.balance_out[`PSB_BAL_CELL7_BIT] = 1'b0;  // [R13]
        end
        // wake request pin exists only on the lower device [R12] [R14]
        r_d.wake_req = !UPPER_DEVICE && r_q.balance_reg[`PSB_BAL_WAKE_BIT];
    end

    // ==============================================================
    // state register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            r_q          <= '0;
            r_q.scl_prev <= 1'b1;
            r_q.sda_prev <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // open-drain data line only ever pulls low
    assign o_sda_o            = 1'b0;
    assign o_sda_oe           = r_q.sda_oe;
    assign o_balance_on       = r_q.balance_out;
    assign o_wake_request_out = r_q.wake_req;

endmodule

`default_nettype wire

// *** sim/psb_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module psb_regs_asserts
    import psb_pkg::*;
#(
    parameter bit UPPER_DEVICE = 1'b0
) (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda_o,
    input wire logic       o_sda_oe,
    input wire logic       i_wake_pin_above,
    input wire logic       i_wake_polarity,
    input wire logic       i_load_monitor,
    input wire psb_cond_t  i_cond,
    input wire logic [7:1] o_balance_on,
    input wire logic       o_wake_request_out
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================================
    // balance switches and the shared wake request
    chk_wake_follows_bal: assert property (
        o_wake_request_out == (!UPPER_DEVICE && o_balance_on[6]))
        else $error("wake request differs from cell 6 drive");
    chk_upper_no_wake: assert property (UPPER_DEVICE |-> !o_wake_request_out)
        else $error("upper device drives a wake request");
    chk_lower_cell7_off: assert property (!UPPER_DEVICE |-> !o_balance_on[7])
        else $error("lower device drives cell 7");
    chk_cell6_wake_pair: assert property (
        $rose(o_balance_on[6]) && !UPPER_DEVICE |-> $rose(o_wake_request_out))
        else $error("wake request missed cell 6 turn on");
    // switches move only after a byte lands, which is with the bus clock low
    chk_bal_scl_low: assert property (
        !$stable(o_balance_on) && !$past(i_sys_rst) |-> !$past(i_scl, 3))
        else $error("balance drive moved with the bus clock high");
    // ==========================================================
    // quiet outputs out of reset
    chk_reset_bal_zero: assert property ($fell(i_sys_rst) |-> o_balance_on == 7'h00)
        else $error("balance drive not cleared by reset");
    chk_reset_oe_low: assert property ($fell(i_sys_rst) |-> !o_sda_oe [*3])
        else $error("data line pulled right after reset");
    // read data changes only at a clock fall, after capture
    chk_oe_scl_low: assert property ($rose(o_sda_oe) |-> !$past(i_scl, 2))
        else $error("data line pulled while bus clock high");
    cov_wake: cover property ($rose(o_wake_request_out));
    cov_cell7: cover property ($rose(o_balance_on[7]));
    cov_oe: cover property ($rose(o_sda_oe));
endmodule
bind psb_status_balance_regs psb_regs_asserts #(.UPPER_DEVICE(UPPER_DEVICE)) i_chk (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_wake_pin_above(i_wake_pin_above),
    .i_wake_polarity(i_wake_polarity), .i_load_monitor(i_load_monitor), .i_cond(i_cond),
    .o_balance_on(o_balance_on), .o_wake_request_out(o_wake_request_out));
`default_nettype wire

// *** sim/psb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module psb_host_model (
    input  wire logic i_sys_clk,
    input  wire logic i_dev_pull,
    output logic      o_scl,
    output wire logic o_sda
);
    logic host_pull;
    // open drain with pull-up: a released line reads one
    assign o_sda = !(host_pull || i_dev_pull);
    initial begin
        o_scl = 1'b1;
        host_pull = 1'b0;
    end
    // ==========================================================
    // half bus period of six system clocks, changes just after an edge
    task automatic half();
        repeat (6) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic start();
        host_pull = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        host_pull = 1'b1;
        half();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        host_pull = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        host_pull = 1'b0;
        half();
    endtask
    task automatic clk_bit(input logic b, output logic s);
        host_pull = !b;
        half();
        o_scl = 1'b1;
        half();
        s = o_sda;
        o_scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    // last byte ends with a release, which stops the read
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(last, s);
    endtask
endmodule
`default_nettype wire

// *** sim/psb_status_balance_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module psb_status_balance_regs_bench;
    import psb_pkg::*;
    localparam logic [6:0] LO = 7'h28;
    localparam logic [6:0] UP = 7'h29;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       scl, sda, oe_lo, oe_up, wake_lo, wake_up;
    logic       wake_above = 1'b1;
    logic       wake_pol = 1'b1;
    logic       load_mon = 1'b0;
    psb_cond_t  cond = '0;
    logic [7:1] bal_lo, bal_up;
    logic [7:0] d, e;
    int         num_errors = 0;
    int         tests_run = 0;
    // fault patterns and the flags each leaves on the lower and upper device
    logic [5:0] pats [7] = '{6'h20, 6'h10, 6'h0c, 6'h04, 6'h02, 6'h01, 6'h0a};
    logic [7:0] f_lo [7] = '{8'h20, 8'h10, 8'h0c, 8'h04, 8'h02, 8'h01, 8'h02};
    logic [7:0] f_up [7] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #2.5 sys_clk = ~sys_clk;

    psb_status_balance_regs #(.UPPER_DEVICE(1'b0), .DEV_ADDR(LO)) i_dut (
        .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda), .o_sda_o(),
        .o_sda_oe(oe_lo), .i_wake_pin_above(wake_above), .i_wake_polarity(wake_pol),
        .i_load_monitor(load_mon), .i_cond(cond), .o_balance_on(bal_lo),
        .o_wake_request_out(wake_lo));
    psb_status_balance_regs #(.UPPER_DEVICE(1'b1), .DEV_ADDR(UP)) i_dut_up (
        .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda), .o_sda_o(),
        .o_sda_oe(oe_up), .i_wake_pin_above(wake_above), .i_wake_polarity(wake_pol),
        .i_load_monitor(load_mon), .i_cond(cond), .o_balance_on(bal_up),
        .o_wake_request_out(wake_up));
    psb_host_model i_host (
        .i_sys_clk(sys_clk), .i_dev_pull(oe_lo | oe_up), .o_scl(scl), .o_sda(sda));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================================
    // register access: address, pointer, data; every byte the host sends must be acknowledged
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] v);
        logic a0, a1, a2;
        i_host.start();
        i_host.wr_byte({dev, 1'b0}, a0);
        i_host.wr_byte(ofs, a1);
        i_host.wr_byte(v, a2);
        i_host.stop();
        check({5'h00, a0, a1, a2}, 8'h07);
    endtask
    task automatic reg_read(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] v);
        logic a0, a1, a2;
        i_host.start();
        i_host.wr_byte({dev, 1'b0}, a0);
        i_host.wr_byte(ofs, a1);
        i_host.start();
        i_host.wr_byte({dev, 1'b1}, a2);
        i_host.rd_byte(1'b1, v);
        i_host.stop();
        check({5'h00, a0, a1, a2}, 8'h07);
    endtask

    initial begin
        logic a;
        repeat (4) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        // position bits are fixed; wake status follows pin against polarity
        reg_write(LO, 8'h00, 8'hf0);
        reg_write(UP, 8'h00, 8'h70);
        for (int k = 0; k < 4; k++) begin
            {wake_pol, wake_above} = k[1:0];
            reg_read(LO, 8'h00, d);
            check(d, {3'b010, k[1] == k[0], 4'h0});
            reg_read(UP, 8'h00, d);
            check(d, {3'b100, k[1] == k[0], 4'h0});
        end
        // one balance switch at a time, bit 0 kept at zero
        for (int c = 1; c < 8; c++) begin
            e = 8'h01 << c;
            reg_write(LO, 8'h02, e);
            reg_write(UP, 8'h02, e);
            check({bal_lo, wake_lo}, {e[7:1] & 7'h3f, e[6]});
            check({bal_up, wake_up}, {e[7:1], 1'b0});
            reg_read(LO, 8'h02, d);
            check(d, e);
            reg_read(UP, 8'h02, d);
            check(d, e);
        end
        // unmapped place reads zero; a foreign address is never acknowledged
        reg_read(LO, 8'h03, d);
        check(d, 8'h00);
        i_host.start();
        i_host.wr_byte({7'h30, 1'b0}, a);
        i_host.stop();
        check({7'h00, a}, 8'h00);
        // burst read over offsets 0..2, host acks between bytes
        i_host.start();
        i_host.wr_byte({LO, 1'b0}, a);
        i_host.wr_byte(8'h00, a);
        i_host.start();
        i_host.wr_byte({LO, 1'b1}, a);
        i_host.rd_byte(1'b0, d);
        check(d, 8'h50);
        i_host.rd_byte(1'b0, d);
        check(d, 8'h00);
        i_host.rd_byte(1'b1, d);
        check(d, 8'h80);
        i_host.stop();
        // status is read only: a write leaves it clear
        reg_write(LO, 8'h01, 8'h3f);
        reg_read(LO, 8'h01, d);
        check(d, 8'h00);
        // reset in mid-run drops the balance drive and the stored byte
        @(posedge sys_clk);
        #1 sys_rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check({bal_up, wake_up}, 8'h00);
        reg_read(UP, 8'h02, d);
        check(d, 8'h00);
        // flags latch, survive a read while held, clear on the read after release
        for (int k = 0; k < 7; k++) begin
            load_mon = (k != 6);
            cond = psb_cond_t'(pats[k]);
            repeat (4) @(posedge sys_clk);
            #1;
            reg_read(LO, 8'h01, d);
            check(d, f_lo[k]);
            cond = '0;
            reg_read(LO, 8'h01, d);
            check(d, f_lo[k]);
            reg_read(LO, 8'h01, d);
            check(d, 8'h00);
            reg_read(UP, 8'h01, d);
            check(d, f_up[k]);
            reg_read(UP, 8'h01, d);
            check(d, 8'h00);
        end
        summarize();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (90000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
